/* File: hw/umcls_pkg.sv */
// Shared constants for the modem-control and line-status block
package umcls_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [2:0] UMCLS_IDX_MODEM_CONTROL = 3'h4;
   localparam logic [2:0] UMCLS_IDX_LINE_STATUS = 3'h5;
   localparam int UMCLS_BYTE_SHIFT = 2;
   // Modem control fields
   localparam int UMCLS_MC_DTR = 0;
   localparam int UMCLS_MC_RTS = 1;
   localparam int UMCLS_MC_OUT1 = 2;
   localparam int UMCLS_MC_OUT2 = 3;
   localparam int UMCLS_MC_LOOP = 4;
   localparam int UMCLS_MC_ANYRES = 5;
   localparam int UMCLS_MC_THRACC = 6;
   localparam int UMCLS_MC_PRESC = 7;
   localparam logic [7:0] UMCLS_MC_GUARDED = 8'hE0;
   localparam logic [7:0] UMCLS_MC_RESET = 8'h00;
   // Line status fields
   localparam int UMCLS_LS_DR = 0;
   localparam int UMCLS_LS_THRE = 5;
   localparam int UMCLS_LS_TEMT = 6;
   localparam int UMCLS_LS_FERR = 7;
   localparam logic [7:0] UMCLS_LS_RESET = 8'h60;
   // Prescaler ratio and receive FIFO depth
   localparam int UMCLS_DIV_SLOW = 4;
   localparam int UMCLS_RX_DEPTH = 64;
endpackage : umcls_pkg

/* File: hw/umcls_prescale.sv */
// Clock prescaler: one-cycle enable at divide-by-1 or divide-by-4
module umcls_prescale
   import umcls_pkg::*;
#(
   parameter int SLOW_RATIO = UMCLS_DIV_SLOW
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow_sel,
   output logic tick
);
   localparam int CW = $clog2(SLOW_RATIO);
   localparam logic [CW-1:0] LAST = CW'(SLOW_RATIO - 1);
   localparam logic [CW-1:0] ONE = CW'(1);
   logic [CW-1:0] count;

   if (SLOW_RATIO < 2)
   begin : g_ratio_check
      $error("SLOW_RATIO must be at least 2");
   end

   always_ff @(posedge clk)
   begin
      if (rst || !slow_sel || count == LAST)
         count <= '0;
      else
         count <= count + ONE;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         tick <= 1'b0;
      else
         tick <= !slow_sel || count == LAST;
   end
endmodule : umcls_prescale

/* File: hw/umcls_top.sv */
// Modem-control and line-status logic of one UART channel
// Functional notes
// [R1] Resume-any bit resumes halted transmit on receive
// [R2] Store received byte unless filtered flow character
// [R3] Loopback: transmit to receive, controls to status
// [R4] Bit 3 clear floats interrupt, set drives
// [R5] Drive-select pin high forces interrupt driven
// [R6] Loopback: bit 3 feeds carrier-detect status
// [R7] Bit 2 enables ready report outside loopback
// [R8] Loopback: bit 2 feeds ring-indicator status
// [R9] Bit 1 drives request-to-send pin inverted
// [R10] Automatic flow control overrides request-to-send
// [R11] Bit 0 drives terminal-ready pin inverted
// [R12] Upper control bits writable only when enhanced
// [R13] Status bit 7: any errored byte held
// [R14] Status bit 6: transmitter fully idle
// [R15] Status bit 5: last byte moved to shifter
// [R16] Line status at 05H, resets 60H, divisor-gated
// [R17] Modem control at 04H, resets zero, gated
// [R18] Bit 7 selects prescaler divide 1 or 4
// [R19] Bit 6 enables threshold and trigger access
// [R20] Status bit 0: receive data available
// [R21] Loopback holds pins idle, ignores inputs
//
// Decided for this implementation: register access over Avalon-MM.
module umcls_top
   import umcls_pkg::*;
#(
   parameter int RX_DEPTH = UMCLS_RX_DEPTH
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic DIVISOR_ACCESS,
   input wire logic ENHANCED_ENABLE,
   input wire logic AUX_STATUS_BIT0,
   input wire logic AUTO_RTS_ENABLE,
   input wire logic AUTO_RTS_N,
   input wire logic RX_SW_FLOW_ENABLE,
   input wire logic RX_CHAR_VALID,
   input wire logic RX_CHAR_IS_FLOW,
   input wire logic RX_PUSH,
   input wire logic RX_PUSH_ERR,
   input wire logic RX_POP,
   input wire logic RX_POP_ERR,
   input wire logic TX_HOLD_LOAD,
   input wire logic TX_HOLD_TO_SHIFT,
   input wire logic TX_HOLD_LAST,
   input wire logic TX_SHIFT_DONE,
   input wire logic TX_SERIAL_IN,
   input wire logic RX_PIN,
   input wire logic CTS_N_PIN,
   input wire logic DSR_N_PIN,
   input wire logic RI_N_PIN,
   input wire logic CD_N_PIN,
   input wire logic INT_REQUEST,
   input wire logic IRQ_DRIVE_SELECT_PIN,
   output logic TX_PIN,
   output logic RX_TO_RECEIVER,
   output logic [3:0] MODEM_STATUS_HIGH,
   output logic IRQ_OUT,
   output logic IRQ_OE,
   output logic RTS_N_PIN,
   output logic DTR_N_PIN,
   output logic TX_RESUME,
   output logic RX_STORE,
   output logic FIFO_READY_READ_EN,
   output logic THRESHOLD_ACCESS_EN,
   output logic PRESCALE_TICK
);
   localparam int CW = $clog2(RX_DEPTH + 1);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   localparam logic [CW-1:0] CNT_FULL = CW'(RX_DEPTH);
   localparam logic [1:0] LANE_OFF = 2'h0;

   logic [7:0] modem_control;
   logic rx_ready;
   logic hold_empty;
   logic tx_idle;
   logic fifo_error;
   logic shift_busy;
   logic [CW-1:0] rx_count;
   logic [CW-1:0] err_count;
   logic [CW-1:0] next_rx_count;
   logic [CW-1:0] next_err_count;
   logic next_hold_empty;
   logic next_shift_busy;
   logic [2:0] index;
   logic req;
   logic take;
   logic hit_mc;
   logic hit_ls;
   logic loop;
   logic tick;

   if (RX_DEPTH < 1)
   begin : g_depth_check
      $error("RX_DEPTH must be at least 1");
   end

   assign index = AVS_ADDRESS[4:UMCLS_BYTE_SHIFT];
   assign req = AVS_READ || AVS_WRITE;
   // Access completes on the edge where waitrequest is low
   assign take = req && !AVS_WAITREQUEST;
   assign hit_mc = !DIVISOR_ACCESS && index == UMCLS_IDX_MODEM_CONTROL
      && AVS_ADDRESS[1:0] == LANE_OFF; // [R17]
   assign hit_ls = !DIVISOR_ACCESS && index == UMCLS_IDX_LINE_STATUS
      && AVS_ADDRESS[1:0] == LANE_OFF; // [R16]
   assign loop = modem_control[UMCLS_MC_LOOP];

   // One wait state per access keeps read data registered
   always_ff @(posedge CLK)
   begin
      if (RST)
         AVS_WAITREQUEST <= 1'b1;
      else if (req && AVS_WAITREQUEST)
         AVS_WAITREQUEST <= 1'b0;
      else
         AVS_WAITREQUEST <= 1'b1;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         AVS_READDATA <= '0;
      else if (AVS_READ && AVS_WAITREQUEST)
      begin
         if (hit_mc)
            AVS_READDATA <= {24'h000000, modem_control};
         else if (hit_ls)
            AVS_READDATA <= {24'h000000, fifo_error, tx_idle, hold_empty,
               4'h0, rx_ready}; // [R16]
         else
            AVS_READDATA <= '0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         modem_control <= UMCLS_MC_RESET; // [R17]
      else if (take && AVS_WRITE && hit_mc && AVS_BYTEENABLE[0])
      begin
         if (ENHANCED_ENABLE)
            modem_control <= AVS_WRITEDATA[7:0];
         else
            modem_control <= (modem_control & UMCLS_MC_GUARDED)
               | (AVS_WRITEDATA[7:0] & ~UMCLS_MC_GUARDED); // [R12]
      end
   end

   // Receive FIFO occupancy and errored-byte count
   always_comb
   begin
      next_rx_count = rx_count;
      next_err_count = err_count;
      if (RX_PUSH && !RX_POP && rx_count != CNT_FULL)
         next_rx_count = rx_count + CNT_ONE;
      else if (RX_POP && !RX_PUSH && rx_count != '0)
         next_rx_count = rx_count - CNT_ONE;
      if (RX_PUSH && RX_PUSH_ERR && !(RX_POP && RX_POP_ERR)
         && err_count != CNT_FULL)
         next_err_count = err_count + CNT_ONE;
      else if (RX_POP && RX_POP_ERR && !(RX_PUSH && RX_PUSH_ERR)
         && err_count != '0)
         next_err_count = err_count - CNT_ONE;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         rx_count <= '0;
         err_count <= '0;
         rx_ready <= UMCLS_LS_RESET[UMCLS_LS_DR];
         fifo_error <= UMCLS_LS_RESET[UMCLS_LS_FERR];
      end
      else
      begin
         rx_count <= next_rx_count;
         err_count <= next_err_count;
         rx_ready <= next_rx_count != '0; // [R20]
         fifo_error <= next_err_count != '0; // [R13]
      end
   end

   // Transmit side: a move into the shifter wins over a new load
   always_comb
   begin
      next_hold_empty = hold_empty;
      next_shift_busy = shift_busy;
      if (TX_HOLD_TO_SHIFT && TX_HOLD_LAST)
         next_hold_empty = 1'b1; // [R15]
      else if (TX_HOLD_LOAD)
         next_hold_empty = 1'b0;
      if (TX_HOLD_TO_SHIFT)
         next_shift_busy = 1'b1;
      else if (TX_SHIFT_DONE)
         next_shift_busy = 1'b0;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         hold_empty <= UMCLS_LS_RESET[UMCLS_LS_THRE];
         tx_idle <= UMCLS_LS_RESET[UMCLS_LS_TEMT];
         shift_busy <= 1'b0;
      end
      else
      begin
         hold_empty <= next_hold_empty;
         shift_busy <= next_shift_busy;
         tx_idle <= next_hold_empty && !next_shift_busy; // [R14]
      end
   end

   // Receive events and flow resume
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         TX_RESUME <= 1'b0;
         RX_STORE <= 1'b0;
      end
      else
      begin
         TX_RESUME <= RX_CHAR_VALID && modem_control[UMCLS_MC_ANYRES]; // [R1]
         RX_STORE <= RX_CHAR_VALID
            && !(RX_CHAR_IS_FLOW && RX_SW_FLOW_ENABLE); // [R2]
      end
   end

   // Serial and modem routing
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         TX_PIN <= 1'b1;
         RX_TO_RECEIVER <= 1'b1;
         MODEM_STATUS_HIGH <= 4'h0;
         RTS_N_PIN <= 1'b1;
         DTR_N_PIN <= 1'b1;
      end
      else if (loop)
      begin
         TX_PIN <= 1'b1; // [R21]
         RX_TO_RECEIVER <= TX_SERIAL_IN; // [R3]
         MODEM_STATUS_HIGH <= {modem_control[UMCLS_MC_OUT2], // [R6]
            modem_control[UMCLS_MC_OUT1], // [R8]
            modem_control[UMCLS_MC_DTR], // [R11]
            modem_control[UMCLS_MC_RTS]}; // [R9]
         RTS_N_PIN <= 1'b1; // [R21]
         DTR_N_PIN <= 1'b1; // [R21]
      end
      else
      begin
         TX_PIN <= TX_SERIAL_IN;
         RX_TO_RECEIVER <= RX_PIN;
         MODEM_STATUS_HIGH <= ~{CD_N_PIN, RI_N_PIN, DSR_N_PIN, CTS_N_PIN};
         if (AUTO_RTS_ENABLE)
            RTS_N_PIN <= AUTO_RTS_N; // [R10]
         else
            RTS_N_PIN <= !modem_control[UMCLS_MC_RTS]; // [R9]
         DTR_N_PIN <= !modem_control[UMCLS_MC_DTR]; // [R11]
      end
   end

   // Interrupt pin drive and access enables
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         IRQ_OUT <= 1'b0;
         IRQ_OE <= 1'b0;
         FIFO_READY_READ_EN <= 1'b0;
         THRESHOLD_ACCESS_EN <= 1'b0;
         PRESCALE_TICK <= 1'b0;
      end
      else
      begin
         IRQ_OUT <= INT_REQUEST;
         IRQ_OE <= IRQ_DRIVE_SELECT_PIN // [R5]
            || modem_control[UMCLS_MC_OUT2]; // [R4]
         FIFO_READY_READ_EN <= modem_control[UMCLS_MC_OUT1] && !loop
            && !AUX_STATUS_BIT0; // [R7]
         THRESHOLD_ACCESS_EN <= modem_control[UMCLS_MC_THRACC]; // [R19]
         PRESCALE_TICK <= tick;
      end
   end

   // Divider kept apart so its ratio can be changed alone
   umcls_prescale #(
      .SLOW_RATIO(UMCLS_DIV_SLOW)
   ) u_prescale (
      .clk(CLK),
      .rst(RST),
      .slow_sel(modem_control[UMCLS_MC_PRESC]), // [R18]
      .tick(tick)
   );
endmodule : umcls_top

/* File: bench/umcls_assertions.sv */
// Concurrent checks on the modem-control and line-status ports
module umcls_chk
   import umcls_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic DIVISOR_ACCESS,
   input wire logic RX_CHAR_VALID,
   input wire logic RX_CHAR_IS_FLOW,
   input wire logic RX_SW_FLOW_ENABLE,
   input wire logic TX_SERIAL_IN,
   input wire logic IRQ_DRIVE_SELECT_PIN,
   input wire logic TX_PIN,
   input wire logic RX_TO_RECEIVER,
   input wire logic IRQ_OE,
   input wire logic RTS_N_PIN,
   input wire logic DTR_N_PIN,
   input wire logic TX_RESUME,
   input wire logic RX_STORE,
   input wire logic PRESCALE_TICK
);
   timeunit 1ns;
   timeprecision 1ns;
   logic req;
   logic bad;
   logic keep;
   assign req = AVS_READ | AVS_WRITE;
   assign bad = DIVISOR_ACCESS | (AVS_ADDRESS[1:0] != 2'h0) |
      (AVS_ADDRESS[4:2] != UMCLS_IDX_MODEM_CONTROL &&
      AVS_ADDRESS[4:2] != UMCLS_IDX_LINE_STATUS);
   assign keep = RX_CHAR_VALID & ~(RX_CHAR_IS_FLOW & RX_SW_FLOW_ENABLE);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   sequence s_ack;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   a_wait_one: assert property (
      req && AVS_WAITREQUEST |=> s_ack)
      else $error("Access not answered after one wait");
   a_wait_idle: assert property (
      !req && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("Answer without a request");
   a_read_unmap: assert property (
      AVS_READ && AVS_WAITREQUEST && bad |=> AVS_READDATA == 32'h0)
      else $error("Unmapped read returned data");
   a_read_upper: assert property (AVS_READDATA[31:8] == 24'h0)
      else $error("Upper read lanes not zero");
   a_irq_drive: assert property (
      IRQ_DRIVE_SELECT_PIN |=> IRQ_OE)
      else $error("Interrupt floats while select pin high");
   a_loop_pins: assert property (
      !$past(RST) && TX_PIN != $past(TX_SERIAL_IN) |->
      RTS_N_PIN && DTR_N_PIN && RX_TO_RECEIVER == $past(TX_SERIAL_IN))
      else $error("Loopback routing wrong");
   a_rx_store: assert property (
      !$past(RST) |-> RX_STORE == $past(keep))
      else $error("Receive store decision wrong");
   a_tx_resume: assert property (TX_RESUME |-> $past(RX_CHAR_VALID))
      else $error("Resume without received character");
   a_tick_gap: assert property (
      !PRESCALE_TICK [*3] |=> PRESCALE_TICK)
      else $error("Prescaler gap too long");
endmodule : umcls_chk

bind umcls_top umcls_chk u_chk (
   .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .DIVISOR_ACCESS(DIVISOR_ACCESS),
   .RX_CHAR_VALID(RX_CHAR_VALID), .RX_CHAR_IS_FLOW(RX_CHAR_IS_FLOW),
   .RX_SW_FLOW_ENABLE(RX_SW_FLOW_ENABLE), .TX_SERIAL_IN(TX_SERIAL_IN),
   .IRQ_DRIVE_SELECT_PIN(IRQ_DRIVE_SELECT_PIN), .TX_PIN(TX_PIN),
   .RX_TO_RECEIVER(RX_TO_RECEIVER), .IRQ_OE(IRQ_OE), .RTS_N_PIN(RTS_N_PIN),
   .DTR_N_PIN(DTR_N_PIN), .TX_RESUME(TX_RESUME), .RX_STORE(RX_STORE),
   .PRESCALE_TICK(PRESCALE_TICK)
);

/* File: bench/umcls_remote.sv */
// Remote serial port model on the modem lines
module umcls_remote
(
   input wire logic CLK,
   input wire logic TX_PIN,
   input wire logic RTS_N_PIN,
   input wire logic DTR_N_PIN,
   input wire logic [1:0] RING_CD,
   output logic RX_PIN,
   output logic CTS_N_PIN,
   output logic DSR_N_PIN,
   output logic RI_N_PIN,
   output logic CD_N_PIN
);
   timeunit 1ns;
   timeprecision 1ns;
   // Null-modem echo, one clock late like a slow far end
   always @(posedge CLK)
   begin
      RX_PIN <= TX_PIN;
      CTS_N_PIN <= RTS_N_PIN;
      DSR_N_PIN <= DTR_N_PIN;
      {RI_N_PIN, CD_N_PIN} <= RING_CD;
   end
endmodule : umcls_remote

/* File: bench/tb_uart_modem_ctrl_line_status.sv */
// Testbench for the modem-control and line-status block
module tb_uart_modem_ctrl_line_status
   import umcls_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [4:0] A_MC = 5'h10;
   localparam logic [4:0] A_LS = 5'h14;
   logic CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, TX_SERIAL_IN = 1;
   logic [4:0] AVS_ADDRESS = 5'h0;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
   logic [3:0] AVS_BYTEENABLE = 4'hF, MODEM_STATUS_HIGH;
   logic AVS_WAITREQUEST, DIVISOR_ACCESS = 0, ENHANCED_ENABLE = 0;
   logic AUX_STATUS_BIT0 = 0, AUTO_RTS_ENABLE = 0, AUTO_RTS_N = 1;
   logic RX_SW_FLOW_ENABLE = 0, RX_CHAR_VALID = 0, RX_CHAR_IS_FLOW = 0;
   logic RX_PUSH = 0, RX_PUSH_ERR = 0, RX_POP = 0, RX_POP_ERR = 0;
   logic TX_HOLD_LOAD = 0, TX_HOLD_TO_SHIFT = 0, TX_HOLD_LAST = 0;
   logic TX_SHIFT_DONE = 0, INT_REQUEST = 0, IRQ_DRIVE_SELECT_PIN = 0;
   logic RX_PIN, CTS_N_PIN, DSR_N_PIN, RI_N_PIN, CD_N_PIN, TX_PIN, r;
   logic RX_TO_RECEIVER, IRQ_OUT, IRQ_OE, RTS_N_PIN, DTR_N_PIN, TX_RESUME;
   logic RX_STORE, FIFO_READY_READ_EN, THRESHOLD_ACCESS_EN, PRESCALE_TICK;
   logic [1:0] RING_CD = 2'h3;
   logic [7:0] q[$];
   logic [7:0] v, e8, mc = 8'h0;
   logic [15:0] tl[10] = '{16'hC0E1, 16'h80E1, 16'h3061, 16'h2060,
      16'h0800, 16'h0400, 16'h0100, 16'h0E20, 16'h0720, 16'h0160};
   int n_fail = 0, cmp_count = 0, seed = 32'hbc824d55, i, k;
   umcls_top uut (
      .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .DIVISOR_ACCESS(DIVISOR_ACCESS),
      .ENHANCED_ENABLE(ENHANCED_ENABLE), .AUX_STATUS_BIT0(AUX_STATUS_BIT0),
      .AUTO_RTS_ENABLE(AUTO_RTS_ENABLE), .AUTO_RTS_N(AUTO_RTS_N),
      .RX_SW_FLOW_ENABLE(RX_SW_FLOW_ENABLE), .RX_CHAR_VALID(RX_CHAR_VALID),
      .RX_CHAR_IS_FLOW(RX_CHAR_IS_FLOW), .RX_PUSH(RX_PUSH),
      .RX_PUSH_ERR(RX_PUSH_ERR), .RX_POP(RX_POP), .RX_POP_ERR(RX_POP_ERR),
      .TX_HOLD_LOAD(TX_HOLD_LOAD), .TX_HOLD_TO_SHIFT(TX_HOLD_TO_SHIFT),
      .TX_HOLD_LAST(TX_HOLD_LAST), .TX_SHIFT_DONE(TX_SHIFT_DONE),
      .TX_SERIAL_IN(TX_SERIAL_IN), .RX_PIN(RX_PIN), .CTS_N_PIN(CTS_N_PIN),
      .DSR_N_PIN(DSR_N_PIN), .RI_N_PIN(RI_N_PIN), .CD_N_PIN(CD_N_PIN),
      .INT_REQUEST(INT_REQUEST), .IRQ_DRIVE_SELECT_PIN(IRQ_DRIVE_SELECT_PIN),
      .TX_PIN(TX_PIN), .RX_TO_RECEIVER(RX_TO_RECEIVER),
      .MODEM_STATUS_HIGH(MODEM_STATUS_HIGH), .IRQ_OUT(IRQ_OUT),
      .IRQ_OE(IRQ_OE), .RTS_N_PIN(RTS_N_PIN), .DTR_N_PIN(DTR_N_PIN),
      .TX_RESUME(TX_RESUME), .RX_STORE(RX_STORE),
      .FIFO_READY_READ_EN(FIFO_READY_READ_EN),
      .THRESHOLD_ACCESS_EN(THRESHOLD_ACCESS_EN), .PRESCALE_TICK(PRESCALE_TICK)
   );
   umcls_remote remote (
      .CLK(CLK), .TX_PIN(TX_PIN), .RTS_N_PIN(RTS_N_PIN),
      .DTR_N_PIN(DTR_N_PIN), .RING_CD(RING_CD), .RX_PIN(RX_PIN),
      .CTS_N_PIN(CTS_N_PIN), .DSR_N_PIN(DSR_N_PIN), .RI_N_PIN(RI_N_PIN),
      .CD_N_PIN(CD_N_PIN)
   );
   always #25 CLK = ~CLK;
   task chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task final_report;
      $display("Checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   // Request held until the edge that sees the wait drop
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      AVS_WRITEDATA <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (AVS_WAITREQUEST !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         n_fail++;
         final_report();
      end
      AVS_READ <= 0;
      AVS_WRITE <= 0;
   endtask : bus
   task rd(input logic [4:0] a, input logic [7:0] e);
      q.push_back(e);
      bus(1'b0, a, 8'h0);
   endtask : rd
   task settle;
      repeat (4) @(posedge CLK);
      #1;
   endtask : settle
   // One-cycle pulse pattern on the FIFO and transmit events
   task ev(input logic [7:0] p, input logic [7:0] e);
      @(posedge CLK);
      {RX_PUSH, RX_PUSH_ERR, RX_POP, RX_POP_ERR, TX_HOLD_LOAD,
         TX_HOLD_TO_SHIFT, TX_HOLD_LAST, TX_SHIFT_DONE} <= p;
      @(posedge CLK);
      {RX_PUSH, RX_PUSH_ERR, RX_POP, RX_POP_ERR, TX_HOLD_LOAD,
         TX_HOLD_TO_SHIFT, TX_HOLD_LAST, TX_SHIFT_DONE} <= 8'h0;
      rd(A_LS, e);
   endtask : ev
   always @(posedge CLK)
      if (AVS_READ && AVS_WAITREQUEST === 1'b0)
         chk(AVS_READDATA[7:0], q.size() ? q.pop_front() : 8'hXX);
   initial
   begin
      repeat (2) @(posedge CLK);
      RST <= 0;
      settle();
      chk(8'({RTS_N_PIN, DTR_N_PIN, TX_PIN, IRQ_OE}), 8'hE);
      rd(A_LS, UMCLS_LS_RESET);
      rd(A_MC, UMCLS_MC_RESET);
      for (i = 0; i < 16; i++)
      begin
         @(posedge CLK);
         {ENHANCED_ENABLE, IRQ_DRIVE_SELECT_PIN, AUX_STATUS_BIT0,
            TX_SERIAL_IN, INT_REQUEST, AUTO_RTS_ENABLE, AUTO_RTS_N,
            RING_CD} <= 9'($random(seed));
         v = 8'($random(seed));
         bus(1'b1, A_MC, v);
         mc = ENHANCED_ENABLE ? v : {mc[7:5], v[4:0]};
         r = mc[4] | (AUTO_RTS_ENABLE ? AUTO_RTS_N : !mc[1]);
         settle();
         v = {RTS_N_PIN, DTR_N_PIN, TX_PIN, IRQ_OE, IRQ_OUT,
            FIFO_READY_READ_EN, THRESHOLD_ACCESS_EN, RX_TO_RECEIVER};
         e8 = {r, mc[4] | !mc[0], mc[4] | TX_SERIAL_IN,
            IRQ_DRIVE_SELECT_PIN | mc[3], INT_REQUEST,
            mc[2] & !mc[4] & !AUX_STATUS_BIT0, mc[6], TX_SERIAL_IN};
         chk(v, e8);
         e8 = 8'(mc[4] ? {mc[3], mc[2], mc[0], mc[1]}
            : {!RING_CD[0], !RING_CD[1], mc[0], !r});
         chk(8'(MODEM_STATUS_HIGH), e8);
         k = 0;
         repeat (8)
         begin
            @(posedge CLK);
            k += int'(PRESCALE_TICK);
         end
         chk(8'(k), mc[7] ? 8'h2 : 8'h8);
         rd(A_MC, mc);
      end
      DIVISOR_ACCESS <= 1;
      bus(1'b1, A_MC, ~mc);
      rd(A_LS, 8'h0);
      DIVISOR_ACCESS <= 0;
      rd(A_MC, mc);
      rd(5'h08, 8'h0);
      rd(5'h15, 8'h0);
      for (i = 0; i < 10; i++)
         ev(tl[i][15:8], tl[i][7:0]);
      ENHANCED_ENABLE <= 1;
      for (i = 0; i < 8; i++)
      begin
         bus(1'b1, A_MC, 8'({i[2], 5'h0}));
         @(posedge CLK);
         {RX_CHAR_VALID, RX_CHAR_IS_FLOW, RX_SW_FLOW_ENABLE} <= {1'b1, i[1:0]};
         @(posedge CLK);
         RX_CHAR_VALID <= 0;
         #1;
         e8 = 8'({i[2], i[1:0] != 2'h3});
         chk(8'({TX_RESUME, RX_STORE}), e8);
      end
      final_report();
   end
endmodule : tb_uart_modem_ctrl_line_status
